// ### rtl/iax_regs.vh
// iax_regs.vh: constants for the indexed axis command executor
// assumes inclusion by the design files and the testbench of this block only
`ifndef IAX_REGS_VH
`define IAX_REGS_VH
`define IAX_OP_SOFT_STOP 8'h36
`define IAX_OP_PARAM_WRITE 8'h10
`define IAX_OP_PARAM_READ 8'h11
`define IAX_OP_ACCU_TO_PARAM 8'h12
`define IAX_OP_USER_VAR_WRITE 8'h37
`define IAX_ST_OK 8'h64
`define IAX_ST_BAD_SUM 8'h01
`define IAX_ST_BAD_OP 8'h02
`define IAX_ST_BAD_INDEX 8'h03
`define IAX_PARAM_TARGET_SPEED 8'h00
`define IAX_FRAME_LAST 4'h8
`define IAX_VAR_MAX 32'h0000_00ff
`endif

// ### rtl/iax_frame_rx.v
// iax_frame_rx.v: collects nine command bytes and checks the sum
// assumes bytes arrive one per in_valid pulse, synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "iax_regs.vh"
module iax_frame_rx (
  input wire clock, // system clock
  input wire rst_n, // async reset, low
  input wire [7:0] in_byte, // incoming frame byte
  input wire in_valid, // byte strobe
  output reg frame_done, // pulse: frame complete
  output reg sum_ok, // checksum matched
  output reg [7:0] f_addr, // target address
  output reg [7:0] f_op, // instruction
  output reg [7:0] f_type, // type field
  output reg [7:0] f_bank, // motor/bank field
  output reg [31:0] f_value // value, msb first on wire
);
  reg [3:0] count;
  reg [7:0] sum;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
      sum <= 8'h00;
      frame_done <= 1'b0;
      sum_ok <= 1'b0;
      f_addr <= 8'h00;
      f_op <= 8'h00;
      f_type <= 8'h00;
      f_bank <= 8'h00;
      f_value <= 32'h0000_0000;
    end else begin
      frame_done <= 1'b0;
      if (in_valid) begin
        case (count)
          4'h0: f_addr <= in_byte;
          4'h1: f_op <= in_byte;
          4'h2: f_type <= in_byte;
          4'h3: f_bank <= in_byte;
          4'h4, 4'h5, 4'h6, 4'h7: f_value <= {f_value[23:0], in_byte};
          default: ;
        endcase
        if (count == `IAX_FRAME_LAST) begin
          count <= 4'h0;
          sum <= 8'h00;
          frame_done <= 1'b1;
          sum_ok <= (sum == in_byte);
        end else begin
          count <= count + 4'h1;
          sum <= sum + in_byte;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/iax_exec.v
// iax_exec.v: executes indexed stop, parameter and user variable commands
// assumes axis parameter store and velocity mode logic sit outside
//
// Behaviour
// - Code 54 puts the X axis in velocity mode and writes zero to its target speed parameter.
// - Code 16 writes the frame value to parameter type of the X axis.
// - Code 17 reads parameter type of the X axis into the accumulator.
// - The reply to code 17 carries the value read, with success status.
// - Code 18 copies the accumulator into parameter type of the X axis.
// - Code 55 stores the immediate value into user variable X.
// - Code 55 is not executed when X is negative or above 255.
// - Each successful command answers status 100.
// - A frame is address, instruction, type, bank, four value bytes msb first, checksum.
`timescale 1ns/1ps
`default_nettype none
`include "iax_regs.vh"
module iax_exec #(
  parameter AXIS_W = 8, // axis number width
  parameter VAR_DEPTH = 256 // user variable count
) (
  input wire clock, // system clock
  input wire rst_n, // async reset, low
  input wire [7:0] in_byte, // host frame byte
  input wire in_valid, // host byte strobe
  input wire [7:0] my_addr, // own target address
  input wire [31:0] x_reg, // X register contents
  input wire [31:0] param_rdata, // parameter read data, combinational
  output reg [AXIS_W-1:0] param_axis, // parameter access axis
  output reg [7:0] param_num, // parameter number
  output reg [31:0] param_wdata, // parameter write data
  output reg param_we, // pulse: parameter write
  output reg vel_mode_set, // pulse: select velocity mode
  output reg [31:0] accu, // accumulator
  output reg reply_valid, // pulse: reply ready
  output reg [7:0] reply_status, // reply status code
  output reg [31:0] reply_value, // reply value
  output reg [31:0] var_rdata, // last written user variable
  output reg [7:0] var_rindex // index of that variable
);
  wire frame_done;
  wire sum_ok;
  wire [7:0] f_addr;
  wire [7:0] f_op;
  wire [7:0] f_type;
  wire [7:0] f_bank;
  wire [31:0] f_value;
  reg [31:0] user_var [0:VAR_DEPTH-1];
  // negative x is caught by the unsigned compare: top bit makes it large
  wire x_ok = (x_reg <= `IAX_VAR_MAX);
  wire [7:0] x_idx = x_reg[7:0];
  wire [AXIS_W-1:0] x_axis = x_reg[AXIS_W-1:0];

  // decode, meaningful only while frame_done is high
  wire for_me = frame_done && (f_addr == my_addr);
  wire run_ok = for_me && sum_ok;
  wire op_uvar = (f_op == `IAX_OP_USER_VAR_WRITE);
  // address test matters here too: a frame for another node must not touch our variables
  wire var_we = run_ok && op_uvar && x_ok;

  // next state of every registered output except var_rdata
  reg [AXIS_W-1:0] next_param_axis;
  reg [7:0] next_param_num;
  reg [31:0] next_param_wdata;
  reg next_param_we;
  reg next_vel_mode_set;
  reg [31:0] next_accu;
  reg next_reply_valid;
  reg [7:0] next_reply_status;
  reg [31:0] next_reply_value;
  reg [7:0] next_var_rindex;

  // frame bytes and checksum are handled in the collector
  iax_frame_rx u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .in_byte(in_byte),
    .in_valid(in_valid),
    .frame_done(frame_done),
    .sum_ok(sum_ok),
    .f_addr(f_addr),
    .f_op(f_op),
    .f_type(f_type),
    .f_bank(f_bank),
    .f_value(f_value)
  );

  // user variables have no reset, so a read-back before the first write shows garbage
  always @(posedge clock) begin
    if (var_we) begin
      user_var[x_idx] <= f_value;
    end
  end

  // execution side: parameter port, accumulator and read-back index
  always @* begin
    next_param_axis = x_axis;
    next_param_num = f_type;
    next_param_wdata = param_wdata;
    next_param_we = 1'b0;
    next_vel_mode_set = 1'b0;
    next_accu = accu;
    next_var_rindex = var_rindex;
    // a refused frame leaves param_wdata, accu and var_rindex untouched; param_axis and param_num still follow X and type
    if (run_ok) begin
      case (f_op)
        `IAX_OP_SOFT_STOP: begin
          next_vel_mode_set = 1'b1;
          next_param_num = `IAX_PARAM_TARGET_SPEED;
          next_param_wdata = 32'h0000_0000;
          next_param_we = 1'b1;
        end
        `IAX_OP_PARAM_WRITE: begin
          next_param_wdata = f_value;
          next_param_we = 1'b1;
        end
        `IAX_OP_PARAM_READ: begin
          // read data is combinational, so it is taken in the decode cycle
          next_accu = param_rdata;
        end
        `IAX_OP_ACCU_TO_PARAM: begin
          next_param_wdata = accu;
          next_param_we = 1'b1;
        end
        `IAX_OP_USER_VAR_WRITE: begin
          if (x_ok) begin
            next_var_rindex = x_idx;
          end
        end
        default: begin
          next_param_we = 1'b0;
        end
      endcase
    end
  end

  // reply side: every frame for this address is answered, refused ones too
  always @* begin
    next_reply_valid = 1'b0;
    next_reply_status = reply_status;
    next_reply_value = reply_value;
    if (for_me) begin
      next_reply_valid = 1'b1;
      next_reply_value = 32'h0000_0000;
      if (!sum_ok) begin
        next_reply_status = `IAX_ST_BAD_SUM;
      end else begin
        case (f_op)
          `IAX_OP_SOFT_STOP, `IAX_OP_PARAM_WRITE, `IAX_OP_ACCU_TO_PARAM: begin
            next_reply_status = `IAX_ST_OK;
          end
          `IAX_OP_PARAM_READ: begin
            next_reply_status = `IAX_ST_OK;
            next_reply_value = param_rdata;
          end
          `IAX_OP_USER_VAR_WRITE: begin
            if (x_ok) begin
              next_reply_status = `IAX_ST_OK;
            end else begin
              next_reply_status = `IAX_ST_BAD_INDEX;
            end
          end
          default: begin
            next_reply_status = `IAX_ST_BAD_OP;
          end
        endcase
      end
    end
  end

  // param_axis follows X every cycle; the store must take it with param_we only
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      param_axis <= {AXIS_W{1'b0}};
      param_num <= 8'h00;
      param_wdata <= 32'h0000_0000;
      param_we <= 1'b0;
      vel_mode_set <= 1'b0;
    end else begin
      param_axis <= next_param_axis;
      param_num <= next_param_num;
      param_wdata <= next_param_wdata;
      param_we <= next_param_we;
      vel_mode_set <= next_vel_mode_set;
    end
  end

  // accumulator is loaded only by the indexed read in this group
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      accu <= 32'h0000_0000;
    end else begin
      accu <= next_accu;
    end
  end

  // status holds between frames so a slow host can still pick it up
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reply_valid <= 1'b0;
      reply_status <= 8'h00;
      reply_value <= 32'h0000_0000;
    end else begin
      reply_valid <= next_reply_valid;
      reply_status <= next_reply_status;
      reply_value <= next_reply_value;
    end
  end

  // read-back lags the write by one cycle, as the array is written on the same edge
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      var_rindex <= 8'h00;
      var_rdata <= 32'h0000_0000;
    end else begin
      var_rindex <= next_var_rindex;
      var_rdata <= user_var[var_rindex];
    end
  end
endmodule
`default_nettype wire

// ### verif/iax_exec_monitor.sv
// iax_exec_monitor.sv: port timing checks for the executor
// assumes one clock and frames at least nine cycles apart
`timescale 1ns/1ps
`default_nettype none
module iax_exec_monitor #(parameter AXIS_W = 8) (
  input wire clock, // clock
  input wire rst_n, // reset
  input wire in_valid, // strobe
  input wire [31:0] x_reg, // X
  input wire [AXIS_W-1:0] param_axis, // axis
  input wire [7:0] param_num, // number
  input wire [31:0] param_wdata, // data
  input wire param_we, // write
  input wire vel_mode_set, // velocity
  input wire [31:0] accu, // accu
  input wire reply_valid, // reply
  input wire [7:0] reply_status, // status
  input wire [31:0] reply_value // value
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence one_pulse; reply_valid ##1 !reply_valid; endsequence
  stop_zero_a: assert property (vel_mode_set |-> param_we && param_num == 8'h00
    && param_wdata == 32'h0) else $error("stop write wrong");
  write_ok_a: assert property (param_we |-> reply_valid && reply_status == 8'h64)
    else $error("write without ok reply");
  axis_from_x_a: assert property (param_we |-> param_axis == $past(x_reg[AXIS_W-1:0]))
    else $error("axis not from X");
  reply_late_a: assert property (reply_valid |-> $past(in_valid, 2)) else $error("reply timing");
  reply_pulse_a: assert property (reply_valid |-> one_pulse) else $error("reply not a pulse");
  index_refuse_a: assert property (reply_valid && reply_status == 8'h03 |-> !param_we)
    else $error("bad index executed");
  sum_refuse_a: assert property (reply_valid && reply_status == 8'h01 |-> !param_we
    && !vel_mode_set && $stable(accu)) else $error("bad sum executed");
  accu_reply_a: assert property ($changed(accu) |-> reply_valid && reply_value == accu)
    else $error("accu and reply differ");
endmodule
bind iax_exec iax_exec_monitor #(.AXIS_W(AXIS_W)) mon_u (.clock(clock), .rst_n(rst_n), .in_valid(in_valid),
  .x_reg(x_reg), .param_axis(param_axis), .param_num(param_num), .param_wdata(param_wdata), .param_we(param_we),
  .vel_mode_set(vel_mode_set), .accu(accu), .reply_valid(reply_valid), .reply_status(reply_status),
  .reply_value(reply_value));
`default_nettype wire

// ### verif/iax_host_model.sv
// iax_host_model.sv: host sending frames, plus a parameter store stand-in
// assumes the bench sets the X register before each send
`timescale 1ns/1ps
`default_nettype none
module iax_host_model (
  input wire logic clock, // clock
  input wire logic [31:0] x_reg, // X register
  output logic [7:0] in_byte, // frame byte
  output logic in_valid, // byte strobe
  output logic [31:0] param_rdata // read data
);
  logic [7:0] f [0:8];
  logic [7:0] ty = 8'h00;
  // read data tied to X and the frame type, not to param_axis and param_num of the executor
  assign param_rdata = {x_reg[7:0], ty, 16'h5a5a};
  initial begin
    in_valid = 1'b0;
    in_byte = 8'h00;
  end
  task automatic send(input logic [7:0] a, op, t, b, input logic [31:0] v, input logic bad);
    f = '{a, op, t, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int k = 0; k < 8; k++) f[8] = f[8] + f[k];
    if (bad) f[8] = ~f[8];
    ty = t;
    for (int k = 0; k < 9; k++) begin
      @(posedge clock);
      #1;
      in_byte = f[k];
      in_valid = 1'b1;
    end
    @(posedge clock);
    #1;
    in_valid = 1'b0;
    in_byte = ~in_byte; // released line must not keep the last byte
  endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// tb.sv: directed checks of the indexed command executor
// assumes the host model drives frames and parameter read data
`timescale 1ns/1ps
`default_nettype none
`include "iax_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  logic clock = 0, rst_n = 0, in_valid, we_s, vel_s, got, param_we, vel_mode_set, reply_valid;
  logic [7:0] in_byte, my_addr = 8'h01, param_num, reply_status, var_rindex, param_axis;
  logic [31:0] x_reg = 0, param_rdata, param_wdata, accu, reply_value, var_rdata, exp_v;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #5 clock = ~clock;
  iax_host_model hst (.clock(clock), .x_reg(x_reg), .in_byte(in_byte), .in_valid(in_valid),
    .param_rdata(param_rdata));
  iax_exec dut_u (.clock(clock), .rst_n(rst_n), .in_byte(in_byte), .in_valid(in_valid), .my_addr(my_addr),
    .x_reg(x_reg), .param_rdata(param_rdata), .param_axis(param_axis), .param_num(param_num),
    .param_wdata(param_wdata), .param_we(param_we), .vel_mode_set(vel_mode_set), .accu(accu),
    .reply_valid(reply_valid), .reply_status(reply_status), .reply_value(reply_value),
    .var_rdata(var_rdata), .var_rindex(var_rindex));
  task automatic run(input logic [7:0] a, op, t, input logic [31:0] x, v, input logic bad);
    x_reg = x;
    hst.send(a, op, t, 8'h07, v, bad);
    got = 0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge clock);
      #1;
      got = (reply_valid === 1'b1);
      we_s = param_we;
      vel_s = vel_mode_set;
    end
  endtask
  task t_stop();
    run(8'h01, `IAX_OP_SOFT_STOP, 8'h09, 32'h2, 32'hdeadbeef, 0);
    `CHK("vel", 1'b1, vel_s)
    `CHK("stop", {1'b1, 8'h02, 8'h00, 32'h0}, {we_s, param_axis, param_num, param_wdata})
    `CHK("status", 8'h64, reply_status)
  endtask
  task t_par();
    run(8'h01, `IAX_OP_PARAM_WRITE, 8'h04, 32'h1, 32'h0000c800, 0);
    `CHK("write", {1'b1, 8'h01, 8'h04, 32'hc800}, {we_s, param_axis, param_num, param_wdata})
    run(8'h01, `IAX_OP_PARAM_READ, 8'h05, 32'h3, 32'h0, 0);
    exp_v = 32'h03055a5a;
    `CHK("accu", exp_v, accu)
    `CHK("reply", {8'h64, exp_v}, {reply_status, reply_value})
    run(8'h01, `IAX_OP_ACCU_TO_PARAM, 8'h06, 32'h0, 32'h12345678, 0);
    `CHK("copy", {1'b1, 8'h06, exp_v}, {we_s, param_num, param_wdata})
  endtask
  task t_var();
    run(8'h01, `IAX_OP_USER_VAR_WRITE, 8'h00, 32'hff, 32'h3, 0);
    @(posedge clock);
    #1;
    `CHK("var", {8'hff, 32'h3}, {var_rindex, var_rdata})
    run(8'h01, `IAX_OP_USER_VAR_WRITE, 8'h00, 32'h100, 32'h9, 0);
    `CHK("high", 8'h03, reply_status)
    run(8'h01, `IAX_OP_USER_VAR_WRITE, 8'h00, 32'hffffffff, 32'h9, 0);
    `CHK("neg", {8'h03, 32'h3}, {reply_status, var_rdata})
  endtask
  task t_err();
    run(8'h01, `IAX_OP_PARAM_WRITE, 8'h04, 32'h1, 32'h5, 1);
    `CHK("sum", {8'h01, 1'b0}, {reply_status, we_s})
    run(8'h02, `IAX_OP_PARAM_WRITE, 8'h04, 32'h1, 32'h5, 0);
    `CHK("addr", 1'b0, got)
    run(8'h02, `IAX_OP_USER_VAR_WRITE, 8'h00, 32'hff, 32'h9, 0);
    `CHK("foreign", {1'b0, 8'hff, 32'h3}, {got, var_rindex, var_rdata})
    run(8'h01, 8'h33, 8'h00, 32'h1, 32'h5, 0);
    `CHK("op", {1'b1, 8'h02, 1'b0, 1'b0}, {got, reply_status, we_s, vel_s})
  endtask
  task end_sim();
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1 rst_n = 1;
    t_stop();
    t_par();
    t_var();
    t_err();
    end_sim();
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end
endmodule
`default_nettype wire
